// File: page_mode_dram_controller.sv
// page-mode dram controller: mux, page detector, sequencer, refresh
`timescale 1ns/1ns
// Operation
// - row part of address driven on mux lines, valid when row strobe falls.
// - column part driven on mux lines, valid when column strobes fall.
// - mux turns to column only via select delayed from row strobe.
// - stored row address captured from bits 21..11 on address strobe rise.
// - page match high when current row bits equal stored row bits.
// - thirteen states in four state bits, three codes unused.
// - idle goes to first access state when dram area selected.
// - idle goes straight to first refresh state on refresh request.
// - first access state asserts one row strobe picked by bank bit.
// - first access state asserts the 16-bit size acknowledge.
// - second access state asserts one column strobe for byte, two else.
// - odd byte uses lower column strobe, even byte the upper one.
// - fourth access state drops column strobes and ack, keeps row strobe.
// - page match with area select in fourth access state enters page.
// - page accesses toggle only column strobes, row strobe held low.
// - page miss goes to precharge, then idle, then a new access.
// - last state of each cycle samples refresh request, jumps to refresh.
// - pending processor access waits while a refresh runs.
// - refresh asserts column strobes first, then both row strobes.
// - precharge state follows every refresh.
// - access column strobes only with ack (refresh ones without); one clock after it initially.
// - page-mode ack follows area select combinationally.
// - ack valid 5 ns before second bus state falling edge.
// - synchronous refresh counter reaches terminal count at 186 hex and holds it until acked.
// - terminal count recurs every 15.6 us at 40 ns clock.
// - terminal count sets request; first refresh state acknowledges.
// - refresh acknowledge clears the refresh counter.
// - refresh acknowledge clears the pending request.
module page_mode_dram_controller (
    input wire logic REF_CLK, // 25 mhz processor clock
    input wire logic RSTN, // async reset
    input wire logic [21:0] ADDR, // processor address
    input wire logic ADDR_STROBE_N, // processor address strobe
    input wire logic DRAM_AREA_SEL, // decoded dram area select
    input wire logic XFER_SIZE_HI, // transfer size bit 1
    input wire logic XFER_SIZE_LO, // transfer size bit 0
    input wire logic READ_NWRITE, // high read, low write
    output logic [9:0] DRAM_MUX_ADDR, // row/column address to dram
    output logic ROW_STROBE_BANK_A_N, // row strobe bank a
    output logic ROW_STROBE_BANK_B_N, // row strobe bank b
    output logic COL_STROBE_UPPER_N, // upper byte column strobe
    output logic COL_STROBE_LOWER_N, // lower byte column strobe
    output logic DRAM_WRITE_N, // dram write enable
    output logic SIZE_ACK_0_N, // size ack bit 0
    output logic SIZE_ACK_1_N, // size ack bit 1
    output logic PAGE_MATCH, // registered page match
    output logic REFRESH_REQ, // refresh request pending
    output logic REFRESH_ACK // refresh acknowledge pulse
);

    ////////////////////////////////////////////////////////////////////////
    // input synchronisers
    logic [21:0] addr_m_r, addr_s_r;
    logic [4:0] ctl_m_r, ctl_s_r;
    logic as_n_s, sel_s, size_hi_s, size_lo_s, rd_s, as_n_d_r;

    // two flops on every address and control pin
    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            addr_m_r <= 22'h000000;
            addr_s_r <= 22'h000000;
            ctl_m_r <= 5'h11;
            ctl_s_r <= 5'h11;
        end else begin
            addr_m_r <= ADDR;
            addr_s_r <= addr_m_r;
            ctl_m_r <= {ADDR_STROBE_N, DRAM_AREA_SEL, XFER_SIZE_HI,
                        XFER_SIZE_LO, READ_NWRITE};
            ctl_s_r <= ctl_m_r;
        end
    end

    assign as_n_s = ctl_s_r[4];
    assign sel_s = ctl_s_r[3];
    assign size_hi_s = ctl_s_r[2];
    assign size_lo_s = ctl_s_r[1];
    assign rd_s = ctl_s_r[0];

    ////////////////////////////////////////////////////////////////////////
    // page detector
    logic [10:0] stored_row_addr_r;
    logic page_match;

    // address strobe edge history
    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            as_n_d_r <= 1'b1;
        end else begin
            as_n_d_r <= as_n_s;
        end
    end

    // capture row bits on strobe rise
    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            stored_row_addr_r <= 11'h000;
        end else if (as_n_s && !as_n_d_r) begin
            stored_row_addr_r <= addr_s_r[dram_ctrl_pkg::PAGE_HI:
                dram_ctrl_pkg::PAGE_LO];
        end
    end

    // compare as soon as the address shows
    assign page_match = (addr_s_r[dram_ctrl_pkg::PAGE_HI:
        dram_ctrl_pkg::PAGE_LO] == stored_row_addr_r);

    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            PAGE_MATCH <= 1'b0;
        end else begin
            PAGE_MATCH <= page_match;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // refresh counter and request
    logic [8:0] ref_cnt_r;
    logic ref_tc;

    assign ref_tc = (ref_cnt_r == dram_ctrl_pkg::REFRESH_TC);

    // counts up, cleared by the acknowledge
    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            ref_cnt_r <= dram_ctrl_pkg::REF_CNT_RST;
        end else if (REFRESH_ACK) begin
            ref_cnt_r <= dram_ctrl_pkg::REF_CNT_RST;
        end else if (!ref_tc) begin
            ref_cnt_r <= ref_cnt_r + 9'h001;
        end
    end

    // terminal count sets, ack clears; count stalls at tc until acked
    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            REFRESH_REQ <= 1'b0;
        end else if (ref_tc && !REFRESH_ACK) begin
            REFRESH_REQ <= 1'b1;
        end else if (REFRESH_ACK) begin
            REFRESH_REQ <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // timing state machine
    dram_ctrl_pkg::state_bits_e state_r, state_nxt;
    logic sel_gap_r, new_req, bank_r, bank_nxt, hit, cycle_end;

    // a new processor cycle needs a gap in area select first
    assign new_req = sel_s && sel_gap_r;
    assign hit = new_req && page_match;
    assign bank_nxt = (state_r == dram_ctrl_pkg::IDLE_ST) ?
        addr_s_r[dram_ctrl_pkg::BANK_BIT] : bank_r;
    assign cycle_end = (state_r == dram_ctrl_pkg::ACCESS_ST4) ||
                       (state_r == dram_ctrl_pkg::PAGE_ST3);

    // next state
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            dram_ctrl_pkg::IDLE_ST: begin
                if (REFRESH_REQ) begin
                    state_nxt = dram_ctrl_pkg::REFRESH_ST1;
                end else if (new_req) begin
                    state_nxt = dram_ctrl_pkg::ACCESS_ST1;
                end
            end
            dram_ctrl_pkg::ACCESS_ST1: state_nxt = dram_ctrl_pkg::ACCESS_ST2;
            dram_ctrl_pkg::ACCESS_ST2: state_nxt = dram_ctrl_pkg::ACCESS_ST3;
            dram_ctrl_pkg::ACCESS_ST3: state_nxt = dram_ctrl_pkg::ACCESS_ST4;
            dram_ctrl_pkg::ACCESS_ST4, dram_ctrl_pkg::PAGE_ST3: begin
                if (REFRESH_REQ) begin
                    state_nxt = dram_ctrl_pkg::REFRESH_ST1;
                end else if (hit) begin
                    state_nxt = dram_ctrl_pkg::PAGE_ST1;
                end else if (new_req) begin
                    state_nxt = dram_ctrl_pkg::ROW_PRECHARGE_ST;
                end
            end
            dram_ctrl_pkg::PAGE_ST1: state_nxt = dram_ctrl_pkg::PAGE_ST2;
            dram_ctrl_pkg::PAGE_ST2: state_nxt = dram_ctrl_pkg::PAGE_ST3;
            dram_ctrl_pkg::ROW_PRECHARGE_ST: state_nxt = dram_ctrl_pkg::IDLE_ST;
            // refresh ignores area select until done
            dram_ctrl_pkg::REFRESH_ST1:
                state_nxt = dram_ctrl_pkg::REFRESH_ST2;
            dram_ctrl_pkg::REFRESH_ST2: state_nxt = dram_ctrl_pkg::REFRESH_ST3;
            dram_ctrl_pkg::REFRESH_ST3: state_nxt = dram_ctrl_pkg::REFRESH_ST4;
            dram_ctrl_pkg::REFRESH_ST4:
                state_nxt = dram_ctrl_pkg::ROW_PRECHARGE_ST;
            default: state_nxt = dram_ctrl_pkg::IDLE_ST;
        endcase
    end

    // state register
    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            state_r <= dram_ctrl_pkg::IDLE_ST;
        end else begin
            state_r <= state_nxt;
        end
    end

    // gap tracker: set while select low, cleared when a cycle starts
    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            sel_gap_r <= 1'b1;
        end else if (!sel_s) begin
            sel_gap_r <= 1'b1;
        end else if (state_nxt == dram_ctrl_pkg::ACCESS_ST1 ||
                     state_nxt == dram_ctrl_pkg::PAGE_ST1) begin
            sel_gap_r <= 1'b0;
        end
    end

    // bank of the open row, taken at access start
    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            bank_r <= 1'b0;
        end else begin
            bank_r <= bank_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // strobes, registered from the next state
    logic row_open, cas_on, ack_reg_on, refr_cas, refr_ras, byte_xfer;

    assign row_open = (state_nxt == dram_ctrl_pkg::ACCESS_ST1) ||
                      (state_nxt == dram_ctrl_pkg::ACCESS_ST2) ||
                      (state_nxt == dram_ctrl_pkg::ACCESS_ST3) ||
                      (state_nxt == dram_ctrl_pkg::ACCESS_ST4) ||
                      (state_nxt == dram_ctrl_pkg::PAGE_ST1) ||
                      (state_nxt == dram_ctrl_pkg::PAGE_ST2) ||
                      (state_nxt == dram_ctrl_pkg::PAGE_ST3);
    assign cas_on = (state_nxt == dram_ctrl_pkg::ACCESS_ST2) ||
                    (state_nxt == dram_ctrl_pkg::ACCESS_ST3) ||
                    (state_nxt == dram_ctrl_pkg::PAGE_ST1) ||
                    (state_nxt == dram_ctrl_pkg::PAGE_ST2);
    assign ack_reg_on = (state_nxt == dram_ctrl_pkg::ACCESS_ST1) ||
                        (state_nxt == dram_ctrl_pkg::ACCESS_ST2) ||
                        (state_nxt == dram_ctrl_pkg::ACCESS_ST3);
    assign refr_cas = (state_nxt == dram_ctrl_pkg::REFRESH_ST2) ||
                      (state_nxt == dram_ctrl_pkg::REFRESH_ST3);
    assign refr_ras = (state_nxt == dram_ctrl_pkg::REFRESH_ST3);
    assign byte_xfer = !size_hi_s && size_lo_s;

    // row strobes: selected bank while open, both in refresh
    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            ROW_STROBE_BANK_A_N <= 1'b1;
            ROW_STROBE_BANK_B_N <= 1'b1;
        end else begin
            ROW_STROBE_BANK_A_N <= !((row_open && !bank_nxt) ||
                                     refr_ras);
            ROW_STROBE_BANK_B_N <= !((row_open && bank_nxt) ||
                                     refr_ras);
        end
    end

    // column strobes: byte lanes on access, both on refresh
    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            COL_STROBE_UPPER_N <= 1'b1;
            COL_STROBE_LOWER_N <= 1'b1;
        end else begin
            COL_STROBE_UPPER_N <= !((cas_on && !(byte_xfer && addr_s_r[0]))
                                  || refr_cas);
            COL_STROBE_LOWER_N <= !((cas_on && !(byte_xfer && !addr_s_r[0]))
                                  || refr_cas);
        end
    end

    // write enable set up with the row, ahead of column strobes
    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            DRAM_WRITE_N <= 1'b1;
        end else begin
            DRAM_WRITE_N <= !(row_open && !rd_s);
        end
    end

    // refresh ack pulse on entry to first refresh state
    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            REFRESH_ACK <= 1'b0;
        end else begin
            REFRESH_ACK <= (state_nxt == dram_ctrl_pkg::REFRESH_ST1) &&
                           (state_r != dram_ctrl_pkg::REFRESH_ST1);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // size acknowledge: registered initially, combinational on page hits
    logic ack_reg_r, ack_page;

    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            ack_reg_r <= 1'b0;
        end else begin
            ack_reg_r <= ack_reg_on;
        end
    end

    // page ack follows the select ahead of column strobes
    assign ack_page = (cycle_end && hit && !REFRESH_REQ) ||
                      (sel_s && (state_r == dram_ctrl_pkg::PAGE_ST1 ||
                      state_r == dram_ctrl_pkg::PAGE_ST2));
    assign SIZE_ACK_1_N = !(ack_reg_r || ack_page);
    assign SIZE_ACK_0_N = 1'b1; // 16-bit port answer

    ////////////////////////////////////////////////////////////////////////
    // address multiplexer
    logic ras_any_r, mux_col_select;

    // stage one: row strobe seen, stage two: column select
    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            ras_any_r <= 1'b0;
        end else begin
            ras_any_r <= row_open;
        end
    end

    assign mux_col_select = ras_any_r && row_open;

    // row until the select rises, then column
    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            DRAM_MUX_ADDR <= 10'h000;
        end else if (mux_col_select) begin
            DRAM_MUX_ADDR <= addr_s_r[dram_ctrl_pkg::COL_HI:
                dram_ctrl_pkg::COL_LO];
        end else begin
            DRAM_MUX_ADDR <= addr_s_r[dram_ctrl_pkg::ROW_HI:
                dram_ctrl_pkg::ROW_LO];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RSTN);

    sequence s_refresh_body;
        (state_r == dram_ctrl_pkg::REFRESH_ST2) ##1
        (state_r == dram_ctrl_pkg::REFRESH_ST3) ##1
        (state_r == dram_ctrl_pkg::REFRESH_ST4) ##1
        (state_r == dram_ctrl_pkg::ROW_PRECHARGE_ST);
    endsequence

    sequence s_access_body;
        (state_r == dram_ctrl_pkg::ACCESS_ST2) ##1
        (state_r == dram_ctrl_pkg::ACCESS_ST3) ##1
        (state_r == dram_ctrl_pkg::ACCESS_ST4);
    endsequence

    AST_REFRESH_SEQ: assert property (
        state_r == dram_ctrl_pkg::REFRESH_ST1 |=> s_refresh_body)
        else $error("refresh sequence broken");
    AST_ACCESS_SEQ: assert property (
        state_r == dram_ctrl_pkg::ACCESS_ST1 |=> s_access_body)
        else $error("access sequence broken");
    AST_REF_PRIO: assert property (
        state_r == dram_ctrl_pkg::IDLE_ST && REFRESH_REQ
        |=> state_r == dram_ctrl_pkg::REFRESH_ST1)
        else $error("refresh lost priority in idle");
    AST_ONE_ROW: assert property (
        state_r == dram_ctrl_pkg::ACCESS_ST1
        |-> ROW_STROBE_BANK_A_N != ROW_STROBE_BANK_B_N)
        else $error("not exactly one row strobe");
    AST_CAS_NEEDS_ACK: assert property (
        state_r == dram_ctrl_pkg::ACCESS_ST2 && !COL_STROBE_UPPER_N
        |-> $past(!SIZE_ACK_1_N))
        else $error("column strobe without prior ack");
    AST_ST4_HOLD: assert property (
        state_r == dram_ctrl_pkg::ACCESS_ST4 |-> COL_STROBE_UPPER_N &&
        COL_STROBE_LOWER_N && !(ROW_STROBE_BANK_A_N && ROW_STROBE_BANK_B_N))
        else $error("fourth access state strobes wrong");
    AST_CBR_ORDER: assert property (
        state_r == dram_ctrl_pkg::REFRESH_ST3 |-> !ROW_STROBE_BANK_A_N &&
        !ROW_STROBE_BANK_B_N && !$past(COL_STROBE_UPPER_N) &&
        $past(ROW_STROBE_BANK_A_N))
        else $error("row before column in refresh");
    AST_TC_REQ: assert property (
        ref_tc && !REFRESH_ACK |=> REFRESH_REQ)
        else $error("terminal count did not set request");
    AST_ACK_CLEARS: assert property (
        REFRESH_ACK |=> ref_cnt_r == dram_ctrl_pkg::REF_CNT_RST)
        else $error("ack did not clear counter");
    AST_TC_VALUE: assert property (
        $rose(ref_tc) |-> ref_cnt_r == 9'h186 &&
        dram_ctrl_pkg::REFRESH_CYCLES == 390)
        else $error("terminal count at wrong value");
endmodule

// File: dram_ctrl_pkg.sv
// shared constants and state encoding for the page-mode dram controller
package dram_ctrl_pkg;
    // bus and dram geometry
    localparam int ADDR_W = 22;
    localparam int MUX_W = 10;
    localparam int ROW_LO = 11;
    localparam int ROW_HI = 20;
    localparam int PAGE_LO = 11;
    localparam int PAGE_HI = 21;
    localparam int COL_LO = 1;
    localparam int COL_HI = 10;
    localparam int BANK_BIT = 21;
    // refresh timing
    localparam int CLK_PERIOD_NS = 40;
    localparam int REFRESH_INTERVAL_NS = 15600;
    localparam int REFRESH_CYCLES = REFRESH_INTERVAL_NS / CLK_PERIOD_NS;
    localparam int REF_CNT_W = 9;
    localparam logic [8:0] REFRESH_TC = 9'h186;
    localparam logic [8:0] REF_CNT_RST = 9'h000;
    // four state bits, gray along the usual path, three codes unused
    typedef enum logic [3:0] {
        IDLE_ST = 4'h0,
        ACCESS_ST1 = 4'h1,
        ACCESS_ST2 = 4'h3,
        ACCESS_ST3 = 4'h2,
        ACCESS_ST4 = 4'h6,
        PAGE_ST1 = 4'h7,
        PAGE_ST2 = 4'h5,
        PAGE_ST3 = 4'h4,
        ROW_PRECHARGE_ST = 4'hC,
        REFRESH_ST1 = 4'hD,
        REFRESH_ST2 = 4'hF,
        REFRESH_ST3 = 4'hE,
        REFRESH_ST4 = 4'hA
    } state_bits_e;
endpackage

// File: dram_pair_model.sv
// behavioural model of the two dram banks latching row and column addresses
`timescale 1ns/1ns
module dram_pair_model (
    input wire logic clk, // processor clock
    input wire logic [9:0] mux_addr, // multiplexed address lines
    input wire logic row_a_n, // row strobe bank a
    input wire logic row_b_n, // row strobe bank b
    input wire logic col_u_n, // upper column strobe
    input wire logic col_l_n, // lower column strobe
    output logic [9:0] row_lat, // last latched row address
    output logic [9:0] col_lat // last latched column address
);
    logic row_q = 1'b1;
    logic col_q = 1'b1;
    ////////////////////////////////////////////////////////////////////////
    // latch one cycle after a strobe falls, so the address must also hold
    always @(posedge clk) begin
        row_q <= row_a_n & row_b_n;
        col_q <= col_u_n & col_l_n;
        if (row_q && !(row_a_n & row_b_n)) begin
            row_lat <= mux_addr;
        end
        if (col_q && !(col_u_n & col_l_n)) begin
            col_lat <= mux_addr;
        end
    end
endmodule

// File: testbench.sv
// self-checking bench for the page-mode dram controller
`timescale 1ns/1ns
module testbench;
    localparam int RA = 9, RB = 8, CU = 7, CL = 6, WE = 5, AK = 4;
    localparam int PM = 3, RQ = 2, RK = 1, RI = 0;
    logic clk, rst_n = 1'b0, as_n = 1'b1, sel = 1'b0;
    logic size_hi = 1'b1, size_lo = 1'b0, rnw = 1'b1;
    logic [21:0] addr = 22'h000000;
    logic [9:0] mux, row_lat, col_lat;
    logic ras_a_n, ras_b_n, cas_u_n, cas_l_n, we_n, ack0_n, ack1_n;
    logic page_match, ref_req, ref_ack;
    wire logic [9:0] obs;
    int fails = 0, compares = 0, cyc = 0, n;
    assign obs = {ras_a_n, ras_b_n, cas_u_n, cas_l_n, we_n, ack1_n,
        page_match, ref_req, ref_ack, ras_a_n & ras_b_n};
    page_mode_dram_controller DUT (.REF_CLK(clk), .RSTN(rst_n), .ADDR(addr),
        .ADDR_STROBE_N(as_n), .DRAM_AREA_SEL(sel), .XFER_SIZE_HI(size_hi),
        .XFER_SIZE_LO(size_lo), .READ_NWRITE(rnw), .DRAM_MUX_ADDR(mux),
        .ROW_STROBE_BANK_A_N(ras_a_n), .ROW_STROBE_BANK_B_N(ras_b_n),
        .COL_STROBE_UPPER_N(cas_u_n), .COL_STROBE_LOWER_N(cas_l_n),
        .DRAM_WRITE_N(we_n), .SIZE_ACK_0_N(ack0_n), .SIZE_ACK_1_N(ack1_n),
        .PAGE_MATCH(page_match), .REFRESH_REQ(ref_req),
        .REFRESH_ACK(ref_ack));
    dram_pair_model MEM (.clk(clk), .mux_addr(mux), .row_a_n(ras_a_n),
        .row_b_n(ras_b_n), .col_u_n(cas_u_n), .col_l_n(cas_l_n),
        .row_lat(row_lat), .col_lat(col_lat));
    ////////////////////////////////////////////////////////////////////////
    // clock and run-length guard
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            fails++;
            stop_test();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // helpers
    task automatic stop_test();
        $display("compares=%0d fails=%0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk1(input logic got, input logic exp, input string what);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t %s got %b", $time, what, got);
        end
    endtask
    task automatic chk10(input logic [9:0] got, input logic [9:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t address got %h", $time, got);
        end
    endtask
    task automatic tick();
        @(posedge clk);
        #1;
    endtask
    task automatic wait_for(input int idx, input logic lvl, input int lim,
        output int cnt);
        cnt = 0;
        while (obs[idx] !== lvl && cnt < lim) begin
            tick();
            cnt++;
        end
        chk1(obs[idx], lvl, "wait ran out");
    endtask
    task automatic start(input logic [21:0] a, input logic hi, input logic lo,
        input logic rd);
        @(posedge clk);
        addr <= a;
        size_hi <= hi;
        size_lo <= lo;
        rnw <= rd;
        as_n <= 1'b0;
        sel <= 1'b1;
        #1;
    endtask
    task automatic finish_acc();
        @(posedge clk);
        as_n <= 1'b1;
        sel <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic test_reset();
        chk1(obs[RI], 1'b1, "rows");
        chk1(cas_u_n & cas_l_n & we_n & ack0_n & ack1_n, 1'b1, "idle");
        chk1(ref_req | ref_ack, 1'b0, "refresh");
        chk10(mux, 10'h000);
    endtask
    task automatic test_word();
        start(22'h12B4D6, 1'b1, 1'b0, 1'b1);
        wait_for(RA, 1'b0, 8, n);
        chk1(obs[RB], 1'b1, "other bank");
        chk1(obs[AK], 1'b0, "ack");
        chk1(obs[CU], 1'b1, "early cas");
        tick();
        chk10(row_lat, 10'h256);
        chk1(obs[CU] | obs[CL], 1'b0, "word cas");
        chk1(obs[AK], 1'b0, "ack with cas");
        tick();
        chk10(col_lat, 10'h26B);
        wait_for(AK, 1'b1, 6, n);
        chk1(obs[CU] & obs[CL], 1'b1, "cas off");
        chk1(obs[RA], 1'b0, "row held");
        finish_acc();
    endtask
    task automatic test_byte();
        logic [21:0] a;
        for (int i = 0; i < 2; i++) begin
            a = (i == 0) ? 22'h2C3E01 : 22'h3F0F02;
            start(a, 1'b0, 1'b1, 1'b0);
            wait_for(RI, 1'b1, 8, n);
            wait_for(RI, 1'b0, 12, n);
            chk1(obs[PM], 1'b0, "miss");
            chk1(obs[RA], 1'b1, "bank a");
            chk1(obs[WE], 1'b0, "write");
            tick();
            chk1(obs[CU], i == 0, "upper");
            chk1(obs[CL], i != 0, "lower");
            wait_for(AK, 1'b1, 6, n);
            finish_acc();
        end
    endtask
    task automatic test_page();
        for (int i = 0; i < 2; i++) begin
            start(22'h3F0F44 + 22'(i * 2), 1'b1, 1'b0, 1'b1);
            wait_for(AK, 1'b0, 8, n);
            chk1(obs[CU], 1'b1, "ack first");
            wait_for(CU, 1'b0, 4, n);
            chk1(obs[PM], 1'b1, "hit");
            chk1(obs[AK] | obs[RB], 1'b0, "page");
            tick();
            chk10(col_lat, 10'h3A2 + 10'(i));
            chk1(obs[AK] | obs[CU], 1'b0, "ack with page cas");
            wait_for(CU, 1'b1, 6, n);
            chk1(obs[RB], 1'b0, "row kept");
            finish_acc();
        end
    endtask
    task automatic test_refresh();
        int t0;
        wait_for(RQ, 1'b1, 500, n);
        wait_for(RK, 1'b1, 4, n);
        t0 = cyc;
        start(22'h3F0F50, 1'b1, 1'b0, 1'b1);
        wait_for(CU, 1'b0, 4, n);
        chk1(obs[CL], 1'b0, "both cas");
        chk1(obs[RI], 1'b1, "cas first");
        wait_for(RI, 1'b0, 4, n);
        chk1(obs[RA] | obs[RB] | obs[CU], 1'b0, "cbr");
        chk1(obs[RQ], 1'b0, "req clear");
        chk1(obs[AK], 1'b1, "held off");
        wait_for(RI, 1'b1, 4, n);
        chk1(obs[AK], 1'b1, "held off");
        wait_for(RB, 1'b0, 10, n);
        chk1(n >= 2, 1'b1, "precharge");
        wait_for(AK, 1'b1, 8, n);
        finish_acc();
        wait_for(RQ, 1'b1, 500, n);
        n = cyc - t0;
        chk1(n >= 32'h184 && n <= 32'h18A, 1'b1, "interval");
    endtask
    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        test_reset();
        test_word();
        test_byte();
        test_page();
        test_refresh();
        stop_test();
    end
endmodule
